/* uart_flow_trigger_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_trigger_config_map.svh"

module uart_flow_trigger_config #(
    parameter int CNT_W = 7
) (
    // Clock, reset, freeze
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    // Parallel register port
    input  wire logic [2:0]                addr,
    input  wire logic [7:0]                wr_data,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    input  wire logic                      channel_a_select_n,
    input  wire logic                      channel_b_select_n,
    output logic      [7:0]                rd_data,
    // FIFO and line state per channel
    input  wire logic [1:0][CNT_W-1:0]     rx_level,
    input  wire logic [1:0][CNT_W-1:0]     tx_free,
    input  wire logic [1:0]                rx_timeout,
    input  wire logic [1:0]                rx_push,
    input  wire logic [1:0][7:0]           rx_char,
    input  wire logic [1:0]                tx_pending,
    input  wire logic [1:0]                cts_n,
    // Control outputs per channel
    output logic      [1:0]                rts_n,
    output logic      [1:0]                tx_halt,
    output logic      [1:0][15:0]          baud_divisor,
    output logic      [1:0][3:0]           sw_flow_mode,
    output logic      [1:0]                special_char,
    output logic      [1:0]                rs485_driver_enable_out
);

    if (CNT_W < 7) begin : g_chk
        $error("CNT_W must hold a count of 64");
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic uart_flow_trigger_config_pkg::reg_space_t
        space_of(input logic [7:0] line_control_reg);
        if (line_control_reg == `LCR_EFR_KEY) begin
            return uart_flow_trigger_config_pkg::SPACE_EFR;
        end else if (line_control_reg[7:5] == `LCR_AFR_KEY) begin
            return uart_flow_trigger_config_pkg::SPACE_AFR;
        end else if (line_control_reg[`LCR_DLAB]) begin
            return uart_flow_trigger_config_pkg::SPACE_DL;
        end else begin
            return uart_flow_trigger_config_pkg::SPACE_NORM;
        end
    endfunction

    function automatic logic [CNT_W-1:0] lvl(input logic [3:0] f);
        return CNT_W'({f, 2'b00});
    endfunction

    function automatic logic [CNT_W-1:0] trig(input logic [3:0] f,
                                              input logic [6:0] fb);
        return (f == 4'h0) ? CNT_W'(fb) : lvl(f);
    endfunction

    function automatic logic [6:0] rx_fb(input logic [1:0] s);
        case (s)
            2'h0:    return `RX_FB0;
            2'h1:    return `RX_FB1;
            2'h2:    return `RX_FB2;
            default: return `RX_FB3;
        endcase
    endfunction

    function automatic logic [6:0] tx_fb(input logic [1:0] s);
        case (s)
            2'h0:    return `TX_FB0;
            2'h1:    return `TX_FB1;
            2'h2:    return `TX_FB2;
            default: return `TX_FB3;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Per-channel state
    // ------------------------------------------------------------
    uart_flow_trigger_config_pkg::byte_t [1:0] lcr_r, ier_r, fcr_r, mcr_r;
    uart_flow_trigger_config_pkg::byte_t [1:0] efr_r, dll_r, dlh_r;
    uart_flow_trigger_config_pkg::byte_t [1:0] tcr_r, tlr_r, afr_r, xoff2_r;
    uart_flow_trigger_config_pkg::reg_space_t  sp [2];
    logic [1:0]               sel, wr_en, acc, spec_r, rts_r, rdy_en;
    logic [1:0]               tx_rdy, rx_rdy;
    logic [1:0][CNT_W-1:0]    tx_trig, rx_trig;
    logic                     concurrent_write_en, rch;
    logic [7:0]               rdy_byte, rd_nxt;

    assign sel  = {~channel_b_select_n, ~channel_a_select_n};
    assign concurrent_write_en = |(sel & {afr_r[1][`AFR_CONCURRENT_WRITE_EN], afr_r[0][`AFR_CONCURRENT_WRITE_EN]});
    assign rch  = channel_a_select_n;

    // ------------------------------------------------------------
    // Channel logic
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign sp[c]     = space_of(lcr_r[c]);
        assign wr_en[c]  = ce & wr_stb & (sel[c] | concurrent_write_en);
        assign acc[c]    = efr_r[c][`EFR_ENH] & mcr_r[c][`MCR_ACC];
        assign rdy_en[c] = mcr_r[c][`MCR_RDY] & ~mcr_r[c][`MCR_LOOP];
        assign tx_trig[c] = trig(tlr_r[c][3:0], tx_fb(fcr_r[c][5:4]));
        assign rx_trig[c] = trig(tlr_r[c][7:4], rx_fb(fcr_r[c][7:6]));
        assign tx_rdy[c] = tx_free[c] >= tx_trig[c];
        assign rx_rdy[c] = (rx_level[c] > rx_trig[c]) | rx_timeout[c];

        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                lcr_r[c] <= `RST_BYTE;
                ier_r[c] <= `RST_BYTE;
                fcr_r[c] <= `RST_BYTE;
                mcr_r[c] <= `RST_BYTE;
            end else if (wr_en[c]) begin
                if (addr == `ADDR_LCR) begin
                    lcr_r[c] <= wr_data;
                end else if (sp[c] == uart_flow_trigger_config_pkg::SPACE_NORM) begin
                    if (addr == `ADDR_IER) begin
                        ier_r[c][3:0] <= wr_data[3:0];
                        if (efr_r[c][`EFR_ENH]) begin
                            ier_r[c][7:4] <= wr_data[7:4];
                        end
                    end else if (addr == `ADDR_FCR) begin
                        fcr_r[c][7:6] <= wr_data[7:6];
                        fcr_r[c][3:0] <= wr_data[3:0];
                        if (efr_r[c][`EFR_ENH]) begin
                            fcr_r[c][5:4] <= wr_data[5:4];
                        end
                    end else if (addr == `ADDR_MCR) begin
                        mcr_r[c][4:0] <= wr_data[4:0];
                        if (efr_r[c][`EFR_ENH]) begin
                            mcr_r[c][7:5] <= wr_data[7:5];
                        end
                    end
                end
            end
        end

        // Enhanced, alternate and divisor registers.
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                efr_r[c]   <= `RST_BYTE;
                afr_r[c]   <= `RST_BYTE;
                xoff2_r[c] <= `RST_BYTE;
                dll_r[c]   <= `RST_BYTE;
                dlh_r[c]   <= `RST_BYTE;
            end else if (wr_en[c] &&
                         sp[c] != uart_flow_trigger_config_pkg::SPACE_NORM) begin
                if (addr == `ADDR_DLL && !ier_r[c][`IER_SLEEP]) begin
                    dll_r[c] <= wr_data;
                end else if (addr == `ADDR_DLH && !ier_r[c][`IER_SLEEP]) begin
                    dlh_r[c] <= wr_data;
                end else if (addr == `ADDR_FCR &&
                             sp[c] == uart_flow_trigger_config_pkg::SPACE_EFR) begin
                    efr_r[c] <= wr_data;
                end else if (addr == `ADDR_FCR &&
                             sp[c] == uart_flow_trigger_config_pkg::SPACE_AFR) begin
                    afr_r[c] <= wr_data;
                end else if (addr == `ADDR_TLR &&
                             sp[c] == uart_flow_trigger_config_pkg::SPACE_EFR) begin
                    xoff2_r[c] <= wr_data;
                end
            end
        end

        // Thresholds are opened by the access bit in normal space.
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                tcr_r[c] <= `RST_BYTE;
                tlr_r[c] <= `RST_BYTE;
            end else if (wr_en[c] && acc[c] &&
                         sp[c] == uart_flow_trigger_config_pkg::SPACE_NORM) begin
                if (addr == `ADDR_TCR) begin
                    tcr_r[c] <= wr_data;
                end else if (addr == `ADDR_TLR) begin
                    tlr_r[c] <= wr_data;
                end
            end
        end

        // Set wins over the read that clears the flag.
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                spec_r[c] <= 1'b0;
            end else if (ce) begin
                if (rx_push[c] && efr_r[c][`EFR_SPEC] && rx_char[c] == xoff2_r[c]) begin
                    spec_r[c] <= 1'b1;
                end else if (rd_stb && sel[c] && addr == `ADDR_FCR &&
                             sp[c] == uart_flow_trigger_config_pkg::SPACE_NORM) begin
                    spec_r[c] <= 1'b0;
                end
            end
        end

        // Halt wins when both levels match, so a bad setting stops the far end.
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                rts_r[c] <= 1'b0;
            end else if (ce) begin
                if (!efr_r[c][`EFR_ARTS]) begin
                    rts_r[c] <= 1'b0;
                end else if (rx_level[c] >= lvl(tcr_r[c][3:0])) begin
                    rts_r[c] <= 1'b1;
                end else if (rx_level[c] <= lvl(tcr_r[c][7:4])) begin
                    rts_r[c] <= 1'b0;
                end
            end
        end

        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                tx_halt[c]                 <= 1'b0;
                rs485_driver_enable_out[c] <= 1'b0;
            end else if (ce) begin
                tx_halt[c] <= efr_r[c][`EFR_ACTS] & cts_n[c];
                rs485_driver_enable_out[c] <= afr_r[c][`AFR_485] & tx_pending[c];
            end
        end

        assign rts_n[c] = efr_r[c][`EFR_ARTS] ? rts_r[c] : ~mcr_r[c][`MCR_RTS];
        assign baud_divisor[c] = {dlh_r[c], dll_r[c]};
        assign sw_flow_mode[c] = efr_r[c][3:0];
        assign special_char[c] = spec_r[c];
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    assign rdy_byte = {2'b00, rx_rdy, 2'b00, tx_rdy};

    always_comb begin
        rd_nxt = `RST_BYTE;
        if (addr == `ADDR_LCR) begin
            rd_nxt = lcr_r[rch];
        end else if (sp[rch] == uart_flow_trigger_config_pkg::SPACE_NORM) begin
            if (addr == `ADDR_IER) begin
                rd_nxt = ier_r[rch];
            end else if (addr == `ADDR_FCR) begin
                rd_nxt = {{2{fcr_r[rch][0]}}, 1'b0, spec_r[rch], 3'b000, ~spec_r[rch]};
            end else if (addr == `ADDR_MCR) begin
                rd_nxt = mcr_r[rch];
            end else if (addr == `ADDR_TCR && acc[rch]) begin
                rd_nxt = tcr_r[rch];
            end else if (addr == `ADDR_TLR && acc[rch]) begin
                rd_nxt = tlr_r[rch];
            end else if (addr == `ADDR_TLR && rdy_en[rch]) begin
                rd_nxt = rdy_byte;
            end
        end else if (addr == `ADDR_DLL) begin
            rd_nxt = dll_r[rch];
        end else if (addr == `ADDR_DLH) begin
            rd_nxt = dlh_r[rch];
        end else if (addr == `ADDR_FCR &&
                     sp[rch] == uart_flow_trigger_config_pkg::SPACE_EFR) begin
            rd_nxt = efr_r[rch];
        end else if (addr == `ADDR_FCR &&
                     sp[rch] == uart_flow_trigger_config_pkg::SPACE_AFR) begin
            rd_nxt = afr_r[rch];
        end else if (addr == `ADDR_TLR &&
                     sp[rch] == uart_flow_trigger_config_pkg::SPACE_EFR) begin
            rd_nxt = xoff2_r[rch];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data <= `RST_BYTE;
        end else if (ce && rd_stb && (|sel)) begin
            rd_data <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Assertions on channel A
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic norm0;
    assign norm0 = sp[0] == uart_flow_trigger_config_pkg::SPACE_NORM;

    property p_enh_block;
        wr_en[0] && norm0 && addr == `ADDR_IER && !efr_r[0][`EFR_ENH]
            |=> ier_r[0][7:4] == $past(ier_r[0][7:4]);
    endproperty
    a_enh_block: assert property (p_enh_block) else $error("Enable upper bits changed while locked");

    property p_dl_lock;
        wr_en[0] && !norm0 && addr == `ADDR_DLL && ier_r[0][`IER_SLEEP]
            |=> $stable(baud_divisor[0]);
    endproperty
    a_dl_lock: assert property (p_dl_lock) else $error("Divisor written in sleep");

    property p_dl_write;
        wr_en[0] && !norm0 && addr == `ADDR_DLH && !ier_r[0][`IER_SLEEP]
            |=> baud_divisor[0][15:8] == $past(wr_data);
    endproperty
    a_dl_write: assert property (p_dl_write) else $error("Divisor high byte not loaded");

    property p_tcr_lock;
        wr_en[0] && addr == `ADDR_TCR && !acc[0] |=> $stable(tcr_r[0]);
    endproperty
    a_tcr_lock: assert property (p_tcr_lock) else $error("Threshold written without access");

    property p_tlr_write;
        wr_en[0] && norm0 && addr == `ADDR_TLR && acc[0]
            |=> tlr_r[0] == $past(wr_data);
    endproperty
    a_tlr_write: assert property (p_tlr_write) else $error("Trigger write lost");

    property p_spec;
        ce && rx_push[0] && efr_r[0][`EFR_SPEC] && rx_char[0] == xoff2_r[0]
            |=> special_char[0] ##1 special_char[0] || rd_stb || !ce;
    endproperty
    a_spec: assert property (p_spec) else $error("Special character not flagged");

    property p_rts_halt;
        ce && efr_r[0][`EFR_ARTS] && rx_level[0] >= lvl(tcr_r[0][3:0])
            |=> rts_n[0];
    endproperty
    a_rts_halt: assert property (p_rts_halt) else $error("RTS not raised at halt");

    property p_cts;
        ce && efr_r[0][`EFR_ACTS] && cts_n[0] |=> tx_halt[0];
    endproperty
    a_cts: assert property (p_cts) else $error("Transmit not halted on CTS");

    property p_rdy;
        ce && rd_stb && !channel_a_select_n && norm0 && addr == `ADDR_TLR
            && rdy_en[0] && !acc[0] |=> rd_data == $past(rdy_byte) && rd_data[3:2] == 2'b00;
    endproperty
    a_rdy: assert property (p_rdy) else $error("Ready register read wrong");

    property p_485;
        ce && !afr_r[0][`AFR_485] |=> !rs485_driver_enable_out[0];
    endproperty
    a_485: assert property (p_485) else $error("Driver enable without RS-485 mode");

    c_concurrent_write_en: cover property (wr_en[0] && wr_en[1] && concurrent_write_en);
    c_rts:  cover property (rts_n[0] && efr_r[0][`EFR_ARTS] ##[1:50] !rts_n[0]);
    c_spec: cover property (special_char[0] ##1 !special_char[0]);

endmodule // uart_flow_trigger_config
`default_nettype wire

/* uart_flow_trigger_config_map.svh */
`ifndef UART_FLOW_TRIGGER_CONFIG_MAP_SVH
`define UART_FLOW_TRIGGER_CONFIG_MAP_SVH
// Register addresses on the parallel port.
`define ADDR_DLL     3'h0
`define ADDR_DLH     3'h1
`define ADDR_IER     3'h1
`define ADDR_FCR     3'h2
`define ADDR_LCR     3'h3
`define ADDR_MCR     3'h4
`define ADDR_TCR     3'h6
`define ADDR_TLR     3'h7
// Line-control patterns that open the extra register spaces.
`define LCR_EFR_KEY  8'hBF
`define LCR_AFR_KEY  3'h4
`define LCR_DLAB     7
// Field positions.
`define EFR_ENH      4
`define EFR_SPEC     5
`define EFR_ARTS     6
`define EFR_ACTS     7
`define IER_SLEEP    4
`define MCR_RTS      1
`define MCR_RDY      2
`define MCR_LOOP     4
`define MCR_ACC      6
`define AFR_CONCURRENT_WRITE_EN     0
`define AFR_485      2
`define IIR_SPEC     4
// Reset value of every register.
`define RST_BYTE     8'h00
// Trigger levels used when a trigger field is zero.
`define RX_FB0       7'h08
`define RX_FB1       7'h10
`define RX_FB2       7'h38
`define RX_FB3       7'h3C
`define TX_FB0       7'h08
`define TX_FB1       7'h10
`define TX_FB2       7'h20
`define TX_FB3       7'h38
`endif

/* uart_flow_trigger_config_pkg.sv */
package uart_flow_trigger_config_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        SPACE_NORM,
        SPACE_DL,
        SPACE_AFR,
        SPACE_EFR
    } reg_space_t;
endpackage

/* uart_flow_trigger_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_flow_trigger_config_tb;
    localparam int         CNT_W   = 7;
    localparam int         MAX_CYC = 4000;
    localparam logic [1:0] SEL_A   = 2'h2;
    localparam logic [1:0] SEL_B   = 2'h1;
    logic                  mclk, rst_n, ce, wr_stb, rd_stb, a_sel_n, b_sel_n;
    logic [2:0]            addr;
    logic [7:0]            wr_data, rd_data;
    logic [1:0][CNT_W-1:0] rx_level, tx_free;
    logic [1:0]            rx_timeout, rx_push, tx_pending, cts_n, rts_n, tx_halt;
    logic [1:0][7:0]       rx_char;
    logic [1:0][15:0]      baud_divisor;
    logic [1:0][3:0]       sw_flow_mode;
    logic [1:0]            special_char, rs485_driver_enable_out;
    int                    fails = 0, cmp_count = 0, cyc_cnt = 0;

    uart_flow_trigger_config #(.CNT_W(CNT_W)) dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .channel_a_select_n(a_sel_n), .channel_b_select_n(b_sel_n), .rd_data(rd_data),
        .rx_level(rx_level), .tx_free(tx_free), .rx_timeout(rx_timeout), .rx_push(rx_push),
        .rx_char(rx_char), .tx_pending(tx_pending), .cts_n(cts_n), .rts_n(rts_n),
        .tx_halt(tx_halt), .baud_divisor(baud_divisor), .sw_flow_mode(sw_flow_mode),
        .special_char(special_char), .rs485_driver_enable_out(rs485_driver_enable_out));

    uart_host_model host_u (.mclk(mclk), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .channel_a_select_n(a_sel_n), .channel_b_select_n(b_sel_n),
        .rd_data(rd_data));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [1:0] s, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(s, a, d);
        check({8'h00, d}, {8'h00, exp});
    endtask

    task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
        host_u.wr(s, a, d);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // The feature register hides behind the 0xBF line-control key.
    task automatic set_efr(input logic [7:0] v);
        wr(SEL_A, 3'h3, 8'hBF);
        wr(SEL_A, 3'h2, v);
        wr(SEL_A, 3'h3, 8'h00);
    endtask

    task automatic push(input int c, input logic [7:0] v);
        @(negedge mclk);
        rx_char[c] = v;
        rx_push[c] = 1'b1;
        @(negedge mclk);
        rx_push[c] = 1'b0;
        cyc(1);
    endtask

    task automatic set_fifo(input int txa, txb, rxa, rxb, input logic [1:0] to);
        @(negedge mclk);
        tx_free[0] = 7'(txa);
        tx_free[1] = 7'(txb);
        rx_level[0] = 7'(rxa);
        rx_level[1] = 7'(rxb);
        rx_timeout = to;
        cyc(1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check({rts_n, tx_halt, special_char, rs485_driver_enable_out, sw_flow_mode}, 16'hC000);
        check(baud_divisor[0] | baud_divisor[1], 16'h0000);
    endtask

    task automatic t_lock();
        wr(SEL_A, 3'h3, 8'h80);
        wr(SEL_A, 3'h0, 8'h34);
        wr(SEL_A, 3'h1, 8'h12);
        check(baud_divisor[0], 16'h1234);
        wr(SEL_A, 3'h3, 8'h00);
        wr(SEL_A, 3'h1, 8'hF0);
        rd_chk(SEL_A, 3'h1, 8'h00);
        set_efr(8'h10);
        wr(SEL_A, 3'h1, 8'h10);
        rd_chk(SEL_A, 3'h1, 8'h10);
        wr(SEL_A, 3'h3, 8'h80);
        wr(SEL_A, 3'h0, 8'hFF);
        check(baud_divisor[0], 16'h1234);
        wr(SEL_A, 3'h3, 8'h00);
        wr(SEL_A, 3'h1, 8'h00);
    endtask

    task automatic t_flow_mode();
        for (int i = 0; i < 16; i++) begin
            set_efr(8'h10 | 8'(i));
            check({8'h00, sw_flow_mode}, 16'(i));
        end
    endtask

    task automatic t_access();
        set_efr(8'h00);
        wr(SEL_A, 3'h4, 8'h40);
        wr(SEL_A, 3'h6, 8'h2A);
        set_efr(8'h10);
        rd_chk(SEL_A, 3'h6, 8'h00);
        wr(SEL_A, 3'h4, 8'h40);
        // Halt above restore, set before auto flow is enabled.
        wr(SEL_A, 3'h6, {host_u.level_field(8), host_u.level_field(20)});
        rd_chk(SEL_A, 3'h6, 8'h25);
        wr(SEL_A, 3'h7, {host_u.level_field(12), host_u.level_field(8)});
        rd_chk(SEL_A, 3'h7, 8'h32);
    endtask

    task automatic t_auto_rts();
        int         lvl [4] = '{19, 20, 9, 8};
        logic [1:0] exp [4] = '{2'h2, 2'h3, 2'h3, 2'h2};
        set_efr(8'h50);
        for (int i = 0; i < 4; i++) begin
            set_fifo(0, 0, lvl[i], 0, 2'h0);
            cyc(1);
            check({14'h0000, rts_n}, {14'h0000, exp[i]});
        end
    endtask

    task automatic t_auto_cts();
        set_efr(8'h90);
        cts_n = 2'h3;
        cyc(2);
        check({14'h0000, tx_halt}, 16'h0001);
        cts_n = 2'h2;
        cyc(2);
        check({14'h0000, tx_halt}, 16'h0000);
        // With the clock enable low the halt output must not follow the pin.
        ce = 1'b0;
        cts_n = 2'h3;
        cyc(2);
        check({14'h0000, tx_halt}, 16'h0000);
        cts_n = 2'h2;
        ce = 1'b1;
        cyc(2);
    endtask

    task automatic t_special();
        wr(SEL_A, 3'h3, 8'hBF);
        wr(SEL_A, 3'h7, 8'h13);
        wr(SEL_A, 3'h2, 8'h30);
        wr(SEL_A, 3'h3, 8'h00);
        push(0, 8'h12);
        check({14'h0000, special_char}, 16'h0000);
        push(0, 8'h13);
        push(1, 8'h13);
        check({14'h0000, special_char}, 16'h0001);
        rd_chk(SEL_A, 3'h2, 8'h10);
        check({14'h0000, special_char}, 16'h0000);
    endtask

    task automatic t_ready();
        wr(SEL_A, 3'h4, 8'h04);
        set_fifo(8, 7, 13, 8, 2'h0);
        rd_chk(SEL_A, 3'h7, 8'h11);
        set_fifo(8, 7, 12, 8, 2'h0);
        rd_chk(SEL_A, 3'h7, 8'h01);
        set_fifo(8, 7, 12, 8, 2'h1);
        rd_chk(SEL_A, 3'h7, 8'h11);
        set_fifo(8, 8, 12, 9, 2'h1);
        rd_chk(SEL_A, 3'h7, 8'h33);
        wr(SEL_A, 3'h4, 8'h00);
        rd_chk(SEL_A, 3'h7, 8'h00);
        wr(SEL_A, 3'h4, 8'h14);
        rd_chk(SEL_A, 3'h7, 8'h00);
        wr(SEL_A, 3'h4, 8'h00);
    endtask

    task automatic t_afr();
        wr(SEL_A, 3'h3, 8'h80);
        wr(SEL_A, 3'h2, 8'h05);
        tx_pending = 2'h3;
        cyc(2);
        check({14'h0000, rs485_driver_enable_out}, 16'h0001);
        wr(SEL_A, 3'h3, 8'h80);
        wr(SEL_A, 3'h0, 8'h56);
        check(baud_divisor[0], 16'h1256);
        check(baud_divisor[1], 16'h0056);
        wr(SEL_A, 3'h2, 8'h04);
        cyc(1);
        check({14'h0000, rs485_driver_enable_out}, 16'h0003);
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc_cnt++;
        if (cyc_cnt == MAX_CYC) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        rx_level = '0;
        tx_free = '0;
        rx_timeout = 2'h0;
        rx_push = 2'h0;
        rx_char = '0;
        tx_pending = 2'h0;
        cts_n = 2'h0;
        cyc(6);
        rst_n = 1'b1;
        t_reset();
        t_lock();
        t_flow_mode();
        t_access();
        t_auto_rts();
        t_auto_cts();
        t_special();
        t_ready();
        t_afr();
        finish_test();
    end
endmodule // uart_flow_trigger_config_tb

`default_nettype wire

/* uart_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_host_model (
    // Clock
    input  wire logic       mclk,
    // Parallel register port
    output var  logic [2:0] addr,
    output var  logic [7:0] wr_data,
    output var  logic       wr_stb,
    output var  logic       rd_stb,
    output var  logic       channel_a_select_n,
    output var  logic       channel_b_select_n,
    input  wire logic [7:0] rd_data
);
    initial begin
        addr = 3'h0;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        channel_a_select_n = 1'b1;
        channel_b_select_n = 1'b1;
    end

    // A released bus shows the inverse of the last value, so a stale byte never passes as data.
    task automatic release_bus();
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        channel_a_select_n = 1'b1;
        channel_b_select_n = 1'b1;
        addr = ~addr;
        wr_data = ~wr_data;
    endtask

    task automatic wr(input logic [1:0] sel_n, input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk);
        {channel_b_select_n, channel_a_select_n} = sel_n;
        addr = a;
        wr_data = d;
        wr_stb = 1'b1;
        @(negedge mclk);
        release_bus();
    endtask

    task automatic rd(input logic [1:0] sel_n, input logic [2:0] a, output logic [7:0] d);
        @(negedge mclk);
        {channel_b_select_n, channel_a_select_n} = sel_n;
        addr = a;
        rd_stb = 1'b1;
        @(negedge mclk);
        d = rd_data;
        release_bus();
    endtask

    function automatic logic [3:0] level_field(input int n);
        return 4'(n / 4);
    endfunction
endmodule // uart_host_model

`default_nettype wire
